// ---- bench/ccdtc_checker.sv ----
// Port-level checker for the timing configuration register bank.
// Assumes it is bound to ccdtc_regs and sees only that module's ports.
module ccdtc_checker
import ccdtc_pkg::*;
#(
   parameter int SYS_TOTAL = 13,
   parameter int LINE_WIDTH = 11
)
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clkEn,
   input wire logic regWrite,
   input wire logic [7:0] regAddr,
   input wire logic [23:0] regData,
   input wire logic [7:0] readAddr,
   input wire logic [23:0] readData,
   input wire logic sysWordValid,
   input wire logic vertical_sync,
   input wire logic dllClock,
   input wire logic data_clock_one,
   input wire logic field_indicator,
   input wire logic dividedTick,
   input wire logic syncSlaveMode,
   input wire logic [9:0] amplifier_gain_word,
   input wire logic [8:0] seq0_repeat_length,
   input wire logic [3:0] seq0_phase_initial_level,
   input wire logic [8:0] seq0_phase2_first_toggle
);
   // ----------------------------------------------------------------
   // Shadow state
   // ----------------------------------------------------------------
   logic [23:0] selReg, next_selReg;
   logic immMode, next_immMode, vsPrev;
   logic [3:0] sinceFall, next_sinceFall;
   logic [3:0] quiet, next_quiet;
   // Mirrors only writes the bank takes; the pin counter stays coarse on purpose
   // Quiet counts cycles since the divider code moved or the bank froze: a tick gap
   // straddling either of them says nothing about the divider
   always_comb
   begin
      next_selReg = (clkEn && regWrite && regAddr == ADDR_CLOCK_SEL) ? regData : selReg;
      next_immMode = (clkEn && regWrite && regAddr == ADDR_UPDATE_MODE) ? regData[0] : immMode;
      next_sinceFall = sinceFall + {3'h0, sinceFall != 4'hf};
      next_quiet = (clkEn && !(regWrite && regAddr == ADDR_CLOCK_SEL))
         ? quiet + {3'h0, quiet != 4'hf} : 4'h0;
      if (vsPrev && !vertical_sync)
         next_sinceFall = 4'h0;
      if (!nrst)
      begin
         next_selReg = CLOCK_SEL_RST;
         next_immMode = 1'b0;
         next_sinceFall = 4'hf;
         next_quiet = 4'h0;
      end
   end
   always_ff @(posedge core_clk)
   begin
      selReg <= next_selReg;
      immMode <= next_immMode;
      sinceFall <= next_sinceFall;
      quiet <= next_quiet;
      vsPrev <= vertical_sync;
   end

   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!nrst);

   property p_readSel;
      $past(clkEn) && $past(nrst) && $past(readAddr) == ADDR_CLOCK_SEL |-> readData == $past(selReg);
   endproperty
   a_readSel: assert property (p_readSel) else $error("clock select readback wrong");
   property p_clkOne;
      $past(clkEn) && $past(nrst) && !selReg[2] && !$past(selReg[2]) |-> data_clock_one == $past(dllClock);
   endproperty
   a_clkOne: assert property (p_clkOne) else $error("data clock one not from dll");
   property p_tick1;
      dividedTick && selReg[1:0] == 2'h1 && quiet >= 4'h2
         |-> $past(dividedTick, 2) && !$past(dividedTick);
   endproperty
   a_tick1: assert property (p_tick1) else $error("divide by two spacing wrong");
   property p_tick3;
      dividedTick && selReg[1:0] == 2'h3 && quiet >= 4'h4
         |-> $past(dividedTick, 4) && !$past(dividedTick, 3)
            && !$past(dividedTick, 2) && !$past(dividedTick);
   endproperty
   a_tick3: assert property (p_tick3) else $error("divide by four spacing wrong");
   property p_slave;
      // Role register loads at the write edge, the output flop one edge later
      clkEn && regWrite && regAddr == ADDR_SYNC_ROLE
         |-> ##2 syncSlaveMode == $past(regData[0], 2);
   endproperty
   a_slave: assert property (p_slave) else $error("sync role not applied");
   property p_gainSync;
      !immMode && $changed(amplifier_gain_word) |-> sinceFall < 4'h8;
   endproperty
   a_gainSync: assert property (p_gainSync) else $error("gain moved away from sync fall");
   property p_gainImm;
      immMode && $past(immMode) && clkEn && regWrite && regAddr == ADDR_GAIN
         |-> ##2 amplifier_gain_word == $past(regData[9:0], 2);
   endproperty
   a_gainImm: assert property (p_gainImm) else $error("immediate gain not applied");
   property p_field;
      $changed(field_indicator) |-> sinceFall < 4'h8;
   endproperty
   a_field: assert property (p_field) else $error("field toggled without sync fall");
   property p_sys;
      $changed({seq0_repeat_length, seq0_phase_initial_level, seq0_phase2_first_toggle})
         |-> $past(sysWordValid, 2);
   endproperty
   a_sys: assert property (p_sys) else $error("sequence fields moved without a word");

   c_tick3: cover property (dividedTick && selReg[1:0] == 2'h3);
   c_imm: cover property (immMode && regWrite && regAddr == ADDR_GAIN);
   c_sys: cover property ($changed(seq0_phase2_first_toggle));
endmodule

bind ccdtc_regs ccdtc_checker #(.SYS_TOTAL(SYS_TOTAL), .LINE_WIDTH(LINE_WIDTH)) chk_u (.*);

// ---- bench/ccdtc_host.sv ----
// Host model that writes the register bank and sends system packets.
// Assumes core_clk is shared with the bank; the bench calls its tasks.
module ccdtc_host
import ccdtc_pkg::*;
(
   input wire logic core_clk,
   output logic regWrite,
   output logic [7:0] regAddr,
   output logic [23:0] regData,
   output logic sysWordValid,
   output logic [31:0] sysWord
);
   // ----------------------------------------------------------------
   // Bus tasks
   // ----------------------------------------------------------------
   // Idle levels at time zero
   initial
   begin
      regWrite = 1'b0;
      regAddr = 8'h00;
      regData = 24'h000000;
      sysWordValid = 1'b0;
      sysWord = 32'h00000000;
   end

   // One write; data is inverted on release so a stale value never looks valid
   task automatic wr(input logic [7:0] a, input logic [23:0] d);
      @(posedge core_clk);
      #1;
      regWrite = 1'b1;
      regAddr = a;
      regData = (a == ADDR_GAIN) ? (d & 24'hecffff) : d;
      @(posedge core_clk);
      #1;
      regWrite = 1'b0;
      regData = ~regData;
   endtask

   // Header, then words back to back with the lowest index first
   task automatic sys(input logic [7:0] a, input logic [23:0] n, input logic [31:0] w [1:13]);
      int cnt;
      cnt = (n == SYS_COUNT_ALL) ? 13 : int'(n);
      @(posedge core_clk);
      #1;
      sysWordValid = 1'b1;
      sysWord = {a, n};
      for (int i = 1; i <= cnt; i++)
      begin
         @(posedge core_clk);
         #1;
         sysWord = w[i];
      end
      @(posedge core_clk);
      #1;
      sysWordValid = 1'b0;
      sysWord = ~sysWord;
   endtask
endmodule

// ---- bench/tb_ccd_timing_config_registers.sv ----
// Self-checking bench for the timing configuration register bank.
// Assumes the host model and the checker are compiled before it.
`define CHK(a, e) begin totalChecks++; if ((a) !== (e)) begin failCount++; \
   $display("unexpected at %0t: value %0h expected %0h", $time, (a), (e)); end end
module tb_ccd_timing_config_registers
import ccdtc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, nrst, clkEn, regWrite, sysWordValid, vertical_sync, raw_input_clock;
   logic dllClock = 1'b0;
   logic lineStrobe, substrate_bias_output, data_clock_one, data_clock_two, pOne, pTwo;
   logic field_indicator, dividedTick, syncSlaveMode;
   logic [7:0] regAddr, readAddr, ticks, t1, t2;
   logic [23:0] regData, readData;
   logic [31:0] sysWord;
   logic [31:0] w [1:13];
   logic [9:0] amplifier_gain_word;
   logic [8:0] seq0_repeat_length, seq0_phase1_first_toggle, seq0_phase1_second_toggle;
   logic [8:0] seq0_phase2_first_toggle;
   logic [3:0] seq0_phase_initial_level;
   int failCount, totalChecks;
   typedef struct packed {logic [7:0] a; logic [23:0] d; logic [23:0] e;} ccdtc_row_t;
   // Address, written value, expected readback
   ccdtc_row_t rows [5] = '{'{ADDR_CLOCK_SEL, 24'h00000f, 24'h00000f},
      '{ADDR_SYNC_ROLE, 24'h000001, 24'h000001}, '{ADDR_SUBSTRATE, 24'h010002, 24'h010002},
      '{ADDR_GAIN, 24'h1302a5, 24'h0002a5}, '{8'h55, 24'h000123, 24'h000000}};

   ccdtc_regs dut_u (.*);
   ccdtc_host host_u (.*);

   // ----------------------------------------------------------------
   // Clocks and helpers
   // ----------------------------------------------------------------
   // Raw clock is slow and unrelated so its path is told apart from the dll path
   initial
   begin
      core_clk = 1'b0;
      raw_input_clock = 1'b0;
      fork
         forever #50 core_clk = ~core_clk;
         forever #730 raw_input_clock = ~raw_input_clock;
      join
   end
   always @(posedge core_clk) #1 dllClock = ~dllClock;
   // Hang guard
   initial
   begin
      #3000000;
      failCount++;
      finishTest();
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [23:0] e);
      readAddr = a;
      cyc(2);
      `CHK(readData, e)
   endtask
   task automatic checkSys(input logic [8:0] len, input logic [3:0] lvl, input logic [8:0] p,
      input logic [8:0] q, input logic [8:0] r);
      `CHK(seq0_repeat_length, len)
      `CHK(seq0_phase_initial_level, lvl)
      `CHK({seq0_phase1_first_toggle, seq0_phase1_second_toggle}, {p, q})
      `CHK(seq0_phase2_first_toggle, r)
   endtask
   task automatic resetChecks;
      checkSys(9'd37, 4'h3, 9'd1, 9'd0, 9'd12);
      `CHK(amplifier_gain_word, 10'h000)
      `CHK(field_indicator, 1'b0)
      rd(ADDR_CLOCK_SEL, 24'h000008);
      `CHK(substrate_bias_output, 1'b0)
   endtask
   task automatic finishTest;
      $display("checks %0d mismatches %0d", totalChecks, failCount);
      if (failCount == 0 && totalChecks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      {nrst, readAddr, vertical_sync, lineStrobe, failCount, totalChecks} = '0;
      clkEn = 1'b1;
      cyc(4);
      nrst = 1'b1;
      resetChecks();
      // A write while frozen is dropped
      clkEn = 1'b0;
      host_u.wr(ADDR_SYNC_ROLE, 24'h000001);
      clkEn = 1'b1;
      rd(ADDR_SYNC_ROLE, 24'h000000);
      `CHK(syncSlaveMode, 1'b0)
      foreach (rows[i])
      begin
         host_u.wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      `CHK(syncSlaveMode, 1'b1)
      `CHK(amplifier_gain_word, 10'h000)
      vertical_sync = 1'b1;
      cyc(6);
      vertical_sync = 1'b0;
      for (int k = 0; k < 10 && amplifier_gain_word !== 10'h2a5; k++)
         cyc(1);
      `CHK(amplifier_gain_word, 10'h2a5)
      `CHK(field_indicator, 1'b1)
      `CHK(substrate_bias_output, 1'b0)
      repeat (2)
      begin
         lineStrobe = 1'b1;
         cyc(1);
         lineStrobe = 1'b0;
         cyc(1);
      end
      cyc(2);
      `CHK(substrate_bias_output, 1'b1)
      host_u.wr(ADDR_UPDATE_MODE, 24'h000001);
      host_u.wr(ADDR_GAIN, 24'h000155);
      cyc(2);
      `CHK(amplifier_gain_word, 10'h155)
      host_u.wr(ADDR_SUBSTRATE, 24'h000002);
      cyc(2);
      `CHK(substrate_bias_output, 1'b0)
      // Each divider code, with both selectors following the code bits
      for (int i = 0; i < 4; i++)
      begin
         host_u.wr(ADDR_CLOCK_SEL, {20'h00000, i[1:0], i[1:0]});
         cyc(8);
         // Count level changes: dll toggles every cycle, raw clock only a few times
         {ticks, t1, t2} = '0;
         repeat (24)
         begin
            {pOne, pTwo} = {data_clock_one, data_clock_two};
            cyc(1);
            ticks += {7'h00, dividedTick};
            t1 += {7'h00, pOne ^ data_clock_one};
            t2 += {7'h00, pTwo ^ data_clock_two};
         end
         `CHK(ticks, 8'(24 / (i + 1)))
         `CHK(t1 > 8'h0c, !i[0])
         `CHK(t2 != 8'h00, i[1])
         // Field has toggled once, so the shared pin shows it high
         if (!i[1])
            `CHK(data_clock_two, 1'b1)
      end
      w = '{default: 32'h5a5a5a5a};
      w[1] = {9'h1aa, 4'ha, 9'h0f3, 9'h155, 1'b1};
      w[2] = {8'h5c, 24'h000000};
      host_u.sys(ADDR_SYSTEM, 24'h000002, w);
      cyc(3);
      checkSys(9'h1aa, 4'ha, 9'h0f3, 9'h155, 9'h15c);
      w[1] = {9'h0c3, 4'h5, 9'h10a, 9'h0ee, 1'b0};
      w[2] = {8'ha7, 24'hffffff};
      host_u.sys(8'h15, 24'h000002, w);
      cyc(3);
      checkSys(9'h1aa, 4'ha, 9'h0f3, 9'h155, 9'h15c);
      host_u.sys(ADDR_SYSTEM, 24'h000000, w);
      cyc(3);
      checkSys(9'h0c3, 4'h5, 9'h10a, 9'h0ee, 9'h0a7);
      nrst = 1'b0;
      cyc(4);
      nrst = 1'b1;
      resetChecks();
      finishTest();
   end
endmodule

// ---- logic/ccdtc_pkg.sv ----
// Constants shared by the timing configuration register bank.
// Assumes a single 10 MHz core clock domain.
package ccdtc_pkg;
   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_UPDATE_MODE = 8'h01;
   localparam logic [7:0] ADDR_SUBSTRATE = 8'h0d;
   localparam logic [7:0] ADDR_GAIN = 8'h0e;
   localparam logic [7:0] ADDR_CLOCK_SEL = 8'hd5;
   localparam logic [7:0] ADDR_SYNC_ROLE = 8'hd6;
   localparam logic [7:0] ADDR_SYSTEM = 8'h14;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int UPDATE_MODE_BIT = 0;
   localparam int SUB_POL_BIT = 16;
   localparam int SUB_LINE_HI = 10;
   localparam int GAIN_HI = 9;
   localparam int CLK_TWO_SEL_BIT = 3;
   localparam int CLK_ONE_SEL_BIT = 2;
   localparam int DIV_HI = 1;
   localparam int SLAVE_BIT = 0;
   localparam int HDR_ADDR_LO = 24;
   localparam int HDR_COUNT_HI = 23;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [23:0] SUBSTRATE_RST = 24'h000000;
   localparam logic [23:0] GAIN_RST = 24'h000000;
   localparam logic [23:0] CLOCK_SEL_RST = 24'h000008;
   localparam logic [23:0] SYNC_ROLE_RST = 24'h000000;
   localparam logic [23:0] UPDATE_MODE_RST = 24'h000000;
   localparam logic [31:0] SYS_WORD1_RST = {9'h025, 4'h3, 9'h001, 9'h000, 1'h0};
   localparam logic [31:0] SYS_WORD2_RST = {8'h0c, 9'h01f, 9'h000, 6'h00};
   localparam logic [23:0] SYS_COUNT_ALL = 24'h000000;

   // Divider codes: 0 none, 1 by two, 2 by three, 3 by four
   localparam logic [1:0] DIV_NONE = 2'h0;

   typedef enum logic {CCDTC_SYS_IDLE, CCDTC_SYS_BODY} ccdtc_sys_state_t;
endpackage

// ---- logic/ccdtc_regs.sv ----
// Timing configuration register bank with system register packet loader.
// Assumes a host writes 24-bit registers and 32-bit system words on core_clk;
// vertical sync and the raw input clock arrive as asynchronous pins.
//
// Behaviour
// - Substrate bias polarity bit 16: 0 active low, 1 active high.
// - Bits 10..0 give substrate bias start line; resets to zero.
// - Clock select bit 3 routes field indicator (0) or raw clock (1); reset 1.
// - Clock select bit 2 routes DLL clock (0) or raw clock (1); reset 0.
// - Divider code 0 none, 1 by two, 2 by three, 3 by four.
// - Sync role bit: 0 master, 1 slave.
// - Frame-synchronous registers start in synchronous update type.
// - Frame-synchronous writes apply at next vertical sync falling edge.
// - Update-type bit at address 0x01 set makes those writes immediate.
// - System block address 0x14 sits in header bits 31..24.
// - Header bits 23..0 count following words; zero means all.
// - Word 1 bits 31..23 hold sequence 0 repeat length.
// - Word 1 bits 22..19 hold four phase initial levels.
// - Phase 1 toggles at word 1 bits 18..10 and 9..1.
// - Phase 2 first toggle: msb word 1 bit 0, low bits word 2 31..24.
module ccdtc_regs
#(
   parameter int SYS_TOTAL = 13,
   parameter int LINE_WIDTH = 11
)
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clkEn,
   input wire logic regWrite,
   input wire logic [7:0] regAddr,
   input wire logic [23:0] regData,
   input wire logic [7:0] readAddr,
   output logic [23:0] readData,
   input wire logic sysWordValid,
   input wire logic [31:0] sysWord,
   input wire logic vertical_sync,
   input wire logic raw_input_clock,
   input wire logic dllClock,
   input wire logic lineStrobe,
   output logic substrate_bias_output,
   output logic data_clock_one,
   output logic data_clock_two,
   output logic field_indicator,
   output logic dividedTick,
   output logic syncSlaveMode,
   output logic [9:0] amplifier_gain_word,
   output logic [8:0] seq0_repeat_length,
   output logic [3:0] seq0_phase_initial_level,
   output logic [8:0] seq0_phase1_first_toggle,
   output logic [8:0] seq0_phase1_second_toggle,
   output logic [8:0] seq0_phase2_first_toggle
);
   import ccdtc_pkg::*;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic vsyncSync;
   logic rawClkSync;

   ccdtc_sync u_vsync
   (
      .core_clk(core_clk),
      .nrst(nrst),
      .clkEn(clkEn),
      .pinIn(vertical_sync),
      .syncOut(vsyncSync)
   );

   ccdtc_sync u_rawclk
   (
      .core_clk(core_clk),
      .nrst(nrst),
      .clkEn(clkEn),
      .pinIn(raw_input_clock),
      .syncOut(rawClkSync)
   );

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic [23:0] updateMode, next_updateMode;
   logic [23:0] subPending, next_subPending;
   logic [23:0] gainPending, next_gainPending;
   logic [23:0] subActive, next_subActive;
   logic [23:0] gainActive, next_gainActive;
   logic [23:0] clockSel, next_clockSel;
   logic [23:0] syncRole, next_syncRole;
   logic [23:0] next_readData;
   logic vsyncLast, next_vsyncLast;
   logic vsyncFall;
   logic immediate;

   assign vsyncFall = vsyncLast & ~vsyncSync;
   // Reset value 0 keeps frame-synchronous type after power-up
   assign immediate = updateMode[UPDATE_MODE_BIT];

   // Host writes and frame-synchronous transfer
   always_comb
   begin
      next_updateMode = updateMode;
      next_subPending = subPending;
      next_gainPending = gainPending;
      next_subActive = subActive;
      next_gainActive = gainActive;
      next_clockSel = clockSel;
      next_syncRole = syncRole;
      next_vsyncLast = vsyncSync;
      // Active copies load from the pending ones at the falling edge
      if (vsyncFall)
      begin
         next_subActive = subPending;
         next_gainActive = gainPending;
      end
      // Test bits stored as written, host keeps them zero
      if (regWrite)
      begin
         case (regAddr)
            ADDR_UPDATE_MODE: next_updateMode = regData;
            ADDR_SUBSTRATE:
            begin
               next_subPending = regData;
               if (immediate)
                  next_subActive = regData;
            end
            ADDR_GAIN:
            begin
               next_gainPending = regData;
               if (immediate)
                  next_gainActive = regData;
            end
            ADDR_CLOCK_SEL: next_clockSel = regData;
            ADDR_SYNC_ROLE: next_syncRole = regData;
            default: next_updateMode = updateMode;
         endcase
      end
      // Reads return what was last written, not yet what is active
      case (readAddr)
         ADDR_UPDATE_MODE: next_readData = updateMode;
         ADDR_SUBSTRATE: next_readData = subPending;
         ADDR_GAIN: next_readData = gainPending;
         ADDR_CLOCK_SEL: next_readData = clockSel;
         ADDR_SYNC_ROLE: next_readData = syncRole;
         default: next_readData = 24'h000000;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         updateMode <= UPDATE_MODE_RST;
         subPending <= SUBSTRATE_RST;
         gainPending <= GAIN_RST;
         subActive <= SUBSTRATE_RST;
         gainActive <= GAIN_RST;
         clockSel <= CLOCK_SEL_RST;
         syncRole <= SYNC_ROLE_RST;
         vsyncLast <= 1'b0;
         readData <= 24'h000000;
      end
      else if (clkEn)
      begin
         updateMode <= next_updateMode;
         subPending <= next_subPending;
         gainPending <= next_gainPending;
         subActive <= next_subActive;
         gainActive <= next_gainActive;
         clockSel <= next_clockSel;
         syncRole <= next_syncRole;
         vsyncLast <= next_vsyncLast;
         readData <= next_readData;
      end
   end

   // ----------------------------------------------------------------
   // Timing outputs
   // ----------------------------------------------------------------
   logic [LINE_WIDTH-1:0] lineCount, next_lineCount;
   logic [1:0] divCount, next_divCount;
   logic next_substrate, next_clkOne, next_clkTwo, next_field, next_tick;
   logic subActiveLevel;

   // Line counting restarts every field
   assign subActiveLevel = lineCount >= subActive[SUB_LINE_HI:0];

   always_comb
   begin
      next_lineCount = lineCount;
      next_field = field_indicator;
      next_divCount = divCount;
      next_tick = 1'b0;
      if (vsyncFall)
      begin
         next_lineCount = '0;
         next_field = ~field_indicator;
      end
      else if (lineStrobe && lineCount != '1)
         next_lineCount = lineCount + 1'b1;
      // Divider as a tick every code+1 cycles
      if (divCount >= clockSel[DIV_HI:0])
      begin
         next_divCount = 2'h0;
         next_tick = 1'b1;
      end
      else
         next_divCount = divCount + 2'h1;
      // Polarity decides which level means active
      next_substrate = subActiveLevel ~^ subActive[SUB_POL_BIT];
      // Shared pin source
      next_clkTwo = clockSel[CLK_TWO_SEL_BIT] ? rawClkSync : next_field;
      // First data clock source
      next_clkOne = clockSel[CLK_ONE_SEL_BIT] ? rawClkSync : dllClock;
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         lineCount <= '0;
         divCount <= DIV_NONE;
         field_indicator <= 1'b0;
         dividedTick <= 1'b0;
         substrate_bias_output <= 1'b1;
         data_clock_one <= 1'b0;
         data_clock_two <= 1'b0;
         syncSlaveMode <= 1'b0;
         amplifier_gain_word <= 10'h000;
      end
      else if (clkEn)
      begin
         lineCount <= next_lineCount;
         divCount <= next_divCount;
         field_indicator <= next_field;
         dividedTick <= next_tick;
         substrate_bias_output <= next_substrate;
         data_clock_one <= next_clkOne;
         data_clock_two <= next_clkTwo;
         syncSlaveMode <= syncRole[SLAVE_BIT];
         amplifier_gain_word <= gainActive[GAIN_HI:0];
      end
   end

   // ----------------------------------------------------------------
   // System register packet loader
   // ----------------------------------------------------------------
   ccdtc_sys_state_t sysState, next_sysState;
   logic [23:0] sysLeft, next_sysLeft;
   logic [23:0] sysIndex, next_sysIndex;
   logic [31:0] sysWordOne, next_sysWordOne;
   logic [31:0] sysWordTwo, next_sysWordTwo;

   // Header then words in ascending index order
   always_comb
   begin
      next_sysState = sysState;
      next_sysLeft = sysLeft;
      next_sysIndex = sysIndex;
      next_sysWordOne = sysWordOne;
      next_sysWordTwo = sysWordTwo;
      case (sysState)
         CCDTC_SYS_IDLE:
         begin
            // Header carries the block address
            if (sysWordValid && sysWord[31:HDR_ADDR_LO] == ADDR_SYSTEM)
            begin
               next_sysState = CCDTC_SYS_BODY;
               next_sysIndex = 24'h000001;
               // Zero count writes the whole block
               if (sysWord[HDR_COUNT_HI:0] == SYS_COUNT_ALL)
                  next_sysLeft = 24'(SYS_TOTAL);
               else
                  next_sysLeft = sysWord[HDR_COUNT_HI:0];
            end
         end
         CCDTC_SYS_BODY:
         begin
            if (sysWordValid)
            begin
               if (sysIndex == 24'h000001)
                  next_sysWordOne = sysWord;
               else if (sysIndex == 24'h000002)
                  next_sysWordTwo = sysWord;
               next_sysIndex = sysIndex + 24'h000001;
               next_sysLeft = sysLeft - 24'h000001;
               if (sysLeft == 24'h000001)
                  next_sysState = CCDTC_SYS_IDLE;
            end
         end
         default: next_sysState = CCDTC_SYS_IDLE;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         sysState <= CCDTC_SYS_IDLE;
         sysLeft <= 24'h000000;
         sysIndex <= 24'h000000;
         sysWordOne <= SYS_WORD1_RST;
         sysWordTwo <= SYS_WORD2_RST;
         seq0_repeat_length <= SYS_WORD1_RST[31:23];
         seq0_phase_initial_level <= SYS_WORD1_RST[22:19];
         seq0_phase1_first_toggle <= SYS_WORD1_RST[18:10];
         seq0_phase1_second_toggle <= SYS_WORD1_RST[9:1];
         seq0_phase2_first_toggle <= {SYS_WORD1_RST[0], SYS_WORD2_RST[31:24]};
      end
      else if (clkEn)
      begin
         sysState <= next_sysState;
         sysLeft <= next_sysLeft;
         sysIndex <= next_sysIndex;
         sysWordOne <= next_sysWordOne;
         sysWordTwo <= next_sysWordTwo;
         seq0_repeat_length <= sysWordOne[31:23];
         seq0_phase_initial_level <= sysWordOne[22:19];
         seq0_phase1_first_toggle <= sysWordOne[18:10];
         seq0_phase1_second_toggle <= sysWordOne[9:1];
         // Split field, earlier word is the msb
         seq0_phase2_first_toggle <= {sysWordOne[0], sysWordTwo[31:24]};
      end
   end
endmodule

// ---- logic/ccdtc_sync.sv ----
// Two-stage synchroniser for one pin level.
// Assumes the input is asynchronous to core_clk.
module ccdtc_sync
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clkEn,
   input wire logic pinIn,
   output logic syncOut
);
   logic stageOne;
   logic next_stageOne;
   logic next_syncOut;

   // ----------------------------------------------------------------
   // Stages
   // ----------------------------------------------------------------
   // First stage feeds only the second
   always_comb
   begin
      next_stageOne = stageOne;
      next_syncOut = syncOut;
      if (clkEn)
      begin
         next_stageOne = pinIn;
         next_syncOut = stageOne;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         stageOne <= 1'b0;
         syncOut <= 1'b0;
      end
      else
      begin
         stageOne <= next_stageOne;
         syncOut <= next_syncOut;
      end
   end
endmodule
